// [rmrb_pkg.sv]
// Package: register map, field layout and carrier types of the runtime misc register bank
package rmrb_pkg;

   // ----------------------------------------------------------------
   // Register offsets (printed offsets are not word multiples: indices)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_FORCE_DISK_CHANGE = 8'h18;
   localparam logic [7:0] IDX_FLOPPY_RATE_SHADOW = 8'h19;
   localparam logic [7:0] IDX_UART_A_FIFO_SHADOW = 8'h1A;
   localparam logic [7:0] IDX_SIRQ_FORCE_LOW_A = 8'h1B;
   localparam logic [7:0] IDX_SIRQ_FORCE_LOW_B = 8'h1C;
   localparam logic [7:0] IDX_UART_B_FIFO_SHADOW = 8'h1D;
   localparam logic [7:0] IDX_RESERVED_TAIL0 = 8'h1E;
   localparam logic [7:0] IDX_RESERVED_TAIL1 = 8'h1F;
   localparam int IDX_SHIFT = 2;

   // ----------------------------------------------------------------
   // Reset values and field masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FORCE_DISK_CHANGE = 8'h01;
   localparam logic [7:0] RST_SIRQ_FORCE_LOW = 8'hFF;
   localparam logic [7:0] MASK_SIRQ_A = 8'hFE;
   localparam logic [7:0] MASK_FLOPPY_RATE = 8'hDF;
   localparam logic [7:0] MASK_UART_FIFO = 8'hCF;
   localparam int FORCE_BIT = 0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // AHB encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   // Floppy data rate / precompensation settings
   typedef struct packed {
      logic softReset;
      logic powerDown;
      logic reserved;
      logic [2:0] writeSelA;
      logic [1:0] dataRate;
   } rmrb_rate_t;

   // UART FIFO control settings
   typedef struct packed {
      logic [1:0] rxTrigger;
      logic [1:0] reserved;
      logic dmaMode;
      logic txFifoReset;
      logic rxFifoReset;
      logic fifoEnable;
   } rmrb_fifo_t;

   // Floppy drive0 interface pins, active low
   typedef struct packed {
      logic diskChangeInN;
      logic headStepPulseN;
      logic driveSelect0N;
   } rmrb_fdd_t;

endpackage

// [rmrb_runtime_misc_register_bank.sv]
// Upper runtime register bank: force disk change, shadows, serial IRQ force-low
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module rmrb_runtime_misc_register_bank (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Floppy drive0 pins and status
   input wire rmrb_pkg::rmrb_fdd_t fddPins,
   output logic diskChangedFlag,
   // Originating control registers in the floppy and UART units
   input wire rmrb_pkg::rmrb_rate_t floppyRateIn,
   input wire rmrb_pkg::rmrb_fifo_t uartAFifoIn,
   input wire rmrb_pkg::rmrb_fifo_t uartBFifoIn,
   // Serial IRQ frame merge
   input wire logic sirqGenEnable,
   input wire logic [15:0] irqFrameOtherN,
   output logic [15:0] irqFrameOutN
);

   // ----------------------------------------------------------------
   // Address phase capture
   // ----------------------------------------------------------------
   logic wrPend_q;
   logic [7:0] wrIdx_q;
   logic [7:0] forceReg_q;
   logic [7:0] sirqA_q;
   logic [7:0] sirqB_q;
   logic [7:0] rdByte_q;
   logic [7:0] rateShadow_q;
   logic [7:0] fifoAShadow_q;
   logic [7:0] fifoBShadow_q;
   logic stepSeen_q;
   // Next values of the writable registers. The read mux looks at these so
   // that a read taken in the data phase of a write to the same register
   // returns the value being written, not the stale one.
   logic [7:0] forceReg_d;
   logic [7:0] sirqA_d;
   logic [7:0] sirqB_d;

   wire addrValid = hsel && hready && (htrans == rmrb_pkg::HTRANS_NONSEQ ||
      htrans == rmrb_pkg::HTRANS_SEQ);
   wire [7:0] addrIdx = {2'h0, haddr[7:rmrb_pkg::IDX_SHIFT]};
   wire [7:0] wrByte = hwdata[7:0];

   // Read mux; unmapped and reserved locations return zero
   function automatic logic [7:0] readSel(input logic [7:0] idx, input logic [7:0] fc,
      input logic [7:0] rs, input logic [7:0] fa, input logic [7:0] sa,
      input logic [7:0] sb, input logic [7:0] fb);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         rmrb_pkg::IDX_FORCE_DISK_CHANGE: v = fc;
         rmrb_pkg::IDX_FLOPPY_RATE_SHADOW: v = rs;
         rmrb_pkg::IDX_UART_A_FIFO_SHADOW: v = fa;
         rmrb_pkg::IDX_SIRQ_FORCE_LOW_A: v = sa;
         rmrb_pkg::IDX_SIRQ_FORCE_LOW_B: v = sb;
         rmrb_pkg::IDX_UART_B_FIFO_SHADOW: v = fb;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Read data registered at the address phase, driven in the data phase.
   // Registering costs nothing here since the slave never waits, and it keeps
   // hrdata free of glitches from the shadow inputs.
   // present bit state
   wire [7:0] rdNext = readSel(addrIdx, forceReg_d, rateShadow_q, fifoAShadow_q,
      sirqA_d, sirqB_d, fifoBShadow_q);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
         wrIdx_q <= 8'h00;
         rdByte_q <= 8'h00;
      end else begin
         wrPend_q <= addrValid && hwrite;
         wrIdx_q <= addrIdx;
         if (addrValid && !hwrite) begin
            rdByte_q <= rdNext;
         end
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, rdByte_q};

   // ----------------------------------------------------------------
   // Force disk change control
   // ----------------------------------------------------------------
   wire wrForce = wrPend_q && wrIdx_q == rmrb_pkg::IDX_FORCE_DISK_CHANGE;
   // A step pulse while drive 0 is selected is the seek that acknowledges the change
   wire stepLow = !fddPins.headStepPulseN && !fddPins.driveSelect0N;
   // Clear on the rising (end) edge of the step with drive selected
   wire stepDone = stepSeen_q && fddPins.headStepPulseN && !fddPins.driveSelect0N;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stepSeen_q <= 1'b0;
      end else begin
         stepSeen_q <= stepLow;
      end
   end

   // Set by software write wins over a hardware clear in the same cycle, so a
   // driver that re-arms the force during a seek never loses the request.
   // A written zero is simply not a term here; reserved bits keep their reset zero.
   wire forceSet = wrForce && wrByte[rmrb_pkg::FORCE_BIT];

   always_comb begin
      forceReg_d = forceReg_q;
      if (forceSet) begin
         forceReg_d[rmrb_pkg::FORCE_BIT] = 1'b1;
      end else if (stepDone) begin
         forceReg_d[rmrb_pkg::FORCE_BIT] = 1'b0;
      end
   end

   // Force register, updated from its next value
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         forceReg_q <= rmrb_pkg::RST_FORCE_DISK_CHANGE;
      end else begin
         forceReg_q <= forceReg_d;
      end
   end

   // Flag is active high as seen in the digital input register bit 7.
   // Pin levels are low active, so the select term is taken as active select.
   // force asserts change
   assign diskChangedFlag = (!fddPins.driveSelect0N && forceReg_q[rmrb_pkg::FORCE_BIT]) ||
      !fddPins.diskChangeInN;

   // ----------------------------------------------------------------
   // Shadow registers
   // ----------------------------------------------------------------
   // track the originating registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rateShadow_q <= 8'h00;
         fifoAShadow_q <= 8'h00;
         fifoBShadow_q <= 8'h00;
      end else begin
         rateShadow_q <= floppyRateIn & rmrb_pkg::MASK_FLOPPY_RATE;
         fifoAShadow_q <= uartAFifoIn & rmrb_pkg::MASK_UART_FIFO;
         fifoBShadow_q <= uartBFifoIn & rmrb_pkg::MASK_UART_FIFO;
      end
   end

   // ----------------------------------------------------------------
   // Serial IRQ force-low registers
   // ----------------------------------------------------------------
   wire wrSirqA = wrPend_q && wrIdx_q == rmrb_pkg::IDX_SIRQ_FORCE_LOW_A;
   wire wrSirqB = wrPend_q && wrIdx_q == rmrb_pkg::IDX_SIRQ_FORCE_LOW_B;

   // Only software writes change these; no hardware path touches them, so a
   // forced frame stays low until the driver itself releases it.
   // write zero asserts frame
   assign sirqA_d = wrSirqA ? (wrByte | ~rmrb_pkg::MASK_SIRQ_A) : sirqA_q;
   assign sirqB_d = wrSirqB ? wrByte : sirqB_q;

   // Force-low registers, updated from their next values
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sirqA_q <= rmrb_pkg::RST_SIRQ_FORCE_LOW;
         sirqB_q <= rmrb_pkg::RST_SIRQ_FORCE_LOW;
      end else begin
         sirqA_q <= sirqA_d;
         sirqB_q <= sirqB_d;
      end
   end

   // Frame n low if forced (when enabled) or if any other source asserts it.
   // Frame 0 is not served by these registers.
   // frames 1 to 15
   wire [15:0] forceVecN = {sirqB_q, sirqA_q[7:1], 1'b1};
   assign irqFrameOutN = sirqGenEnable ? (irqFrameOtherN & forceVecN) : irqFrameOtherN;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // reads observed through hrdata
   a_sirqa_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_SIRQ_FORCE_LOW_A
      |=> hrdata[7:0] == sirqA_q)
      else $error("force-low A readback wrong");
   a_force_no_swclr: assert property (@(posedge clock) disable iff (!resetn)
      wrForce && !stepDone |=> forceReg_q[0] == $past(forceReg_q[0]) || $past(wrByte[0]))
      else $error("force bit cleared by software");
   a_force_hwclear: assert property (@(posedge clock) disable iff (!resetn)
      stepDone && !(wrForce && wrByte[0]) |=> !forceReg_q[0])
      else $error("force bit not cleared by step");
   a_disk_changed_flag_merge: assert property (@(posedge clock) disable iff (!resetn)
      forceReg_q[0] && !fddPins.driveSelect0N |-> diskChangedFlag)
      else $error("disk change not forced");
   a_rate_shadow: assert property (@(posedge clock) disable iff (!resetn)
      ##1 rateShadow_q == ($past(floppyRateIn) & 8'hDF))
      else $error("rate shadow mismatch");
   a_fifo_shadow: assert property (@(posedge clock) disable iff (!resetn)
      ##1 fifoBShadow_q == ($past(uartBFifoIn) & 8'hCF))
      else $error("fifo B shadow mismatch");
   a_frame_forced: assert property (@(posedge clock) disable iff (!resetn)
      sirqGenEnable && !sirqB_q[7] |-> !irqFrameOutN[15])
      else $error("frame 15 not forced low");
   a_frame_gated: assert property (@(posedge clock) disable iff (!resetn)
      !sirqGenEnable |-> irqFrameOutN == irqFrameOtherN)
      else $error("frames forced while disabled");
   a_sirq_hold: assert property (@(posedge clock) disable iff (!resetn)
      !wrSirqB |=> sirqB_q == $past(sirqB_q))
      else $error("force-low B changed without write");
   a_tail_zero: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_RESERVED_TAIL1 |=> hrdata == 32'h0)
      else $error("reserved read nonzero");

   // All checks below are cut off while reset is low, so that the registers
   // jumping to their defaults never counts as a change made by the logic.
   // Reads are judged one cycle after their address phase, when hrdata stands.

   // ----------------------------------------------------------------
   // Assertions: register readback and reserved bits
   // ----------------------------------------------------------------
   // Readback of B must show the written value even right behind a write
   a_sirqb_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_SIRQ_FORCE_LOW_B
      |=> hrdata[7:0] == sirqB_q)
      else $error("force-low B readback wrong");
   // Force register read returns the whole byte, upper bits zero
   a_force_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_FORCE_DISK_CHANGE
      |=> hrdata == {24'h000000, forceReg_q})
      else $error("force register readback wrong");
   // Reserved force bits never become one, whatever is written
   a_force_reserved: assert property (@(posedge clock) disable iff (!resetn)
      forceReg_q[7:1] == 7'h00)
      else $error("reserved force bits set");
   // Upper bytes of read data are always zero
   a_rdata_upper: assert property (@(posedge clock) disable iff (!resetn)
      hrdata[31:8] == 24'h000000)
      else $error("read data upper bytes nonzero");
   // Shadow writes are ignored: the shadow still follows its source
   a_fifoa_shadow: assert property (@(posedge clock) disable iff (!resetn)
      ##1 fifoAShadow_q == ($past(uartAFifoIn) & rmrb_pkg::MASK_UART_FIFO))
      else $error("fifo A shadow mismatch");
   // Shadow reads return the shadow as it stood at the address phase
   a_rate_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_FLOPPY_RATE_SHADOW
      |=> hrdata[7:0] == $past(rateShadow_q))
      else $error("rate shadow readback wrong");
   // UART A shadow readback
   a_fifoa_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_UART_A_FIFO_SHADOW
      |=> hrdata[7:0] == $past(fifoAShadow_q))
      else $error("fifo A shadow readback wrong");
   // UART B shadow readback
   a_fifob_readback: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_UART_B_FIFO_SHADOW
      |=> hrdata[7:0] == $past(fifoBShadow_q))
      else $error("fifo B shadow readback wrong");
   // First reserved location at the top of the bank reads zero
   a_tail0_zero: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && addrIdx == rmrb_pkg::IDX_RESERVED_TAIL0
      |=> hrdata == rmrb_pkg::WORD_ZERO)
      else $error("reserved read nonzero");
   // Locations outside the bank read as zero as well
   a_unmapped_zero: assert property (@(posedge clock) disable iff (!resetn)
      addrValid && !hwrite && (addrIdx < rmrb_pkg::IDX_FORCE_DISK_CHANGE ||
      addrIdx > rmrb_pkg::IDX_RESERVED_TAIL1) |=> hrdata == rmrb_pkg::WORD_ZERO)
      else $error("unmapped read nonzero");
   // Reserved shadow bits are masked off
   a_shadow_reserved: assert property (@(posedge clock) disable iff (!resetn)
      !rateShadow_q[5] && fifoAShadow_q[5:4] == 2'h0 && fifoBShadow_q[5:4] == 2'h0)
      else $error("reserved shadow bits set");

   // ----------------------------------------------------------------
   // Assertions: force disk change
   // ----------------------------------------------------------------
   // A written one always arms the force on the next edge
   a_force_set: assert property (@(posedge clock) disable iff (!resetn)
      wrForce && wrByte[rmrb_pkg::FORCE_BIT] |=> forceReg_q[rmrb_pkg::FORCE_BIT])
      else $error("force bit not set by write");
   // A written zero never arms a cleared force either
   a_force_zero_write: assert property (@(posedge clock) disable iff (!resetn)
      !forceReg_q[0] && wrForce && !wrByte[0] |=> !forceReg_q[0])
      else $error("force bit set by zero write");
   // Without a write or a finished step the force bit stays put
   a_force_hold: assert property (@(posedge clock) disable iff (!resetn)
      !wrForce && !stepDone |=> $stable(forceReg_q))
      else $error("force bit changed without cause");
   // An asserted input pin always shows as changed
   a_disk_changed_flag_input: assert property (@(posedge clock) disable iff (!resetn)
      !fddPins.diskChangeInN |-> diskChangedFlag)
      else $error("disk change input lost");
   // Flag stays low when neither the pin nor a selected force asks for it
   a_disk_changed_flag_idle: assert property (@(posedge clock) disable iff (!resetn)
      fddPins.diskChangeInN && (fddPins.driveSelect0N || !forceReg_q[0]) |-> !diskChangedFlag)
      else $error("disk change flag spurious");

   // ----------------------------------------------------------------
   // Assertions: serial IRQ force-low
   // ----------------------------------------------------------------
   // A write lands exactly as written in register B
   a_sirq_write: assert property (@(posedge clock) disable iff (!resetn)
      wrSirqB |=> sirqB_q == $past(wrByte))
      else $error("force-low B write lost");
   // A written one releases its bit
   a_sirqb_release: assert property (@(posedge clock) disable iff (!resetn)
      wrSirqB && wrByte[0] |=> sirqB_q[0])
      else $error("force-low B bit not released");
   // Register A bit 0 is reserved and never serves a frame
   a_sirqa_bit0: assert property (@(posedge clock) disable iff (!resetn)
      sirqA_q[0] && irqFrameOutN[0] == irqFrameOtherN[0])
      else $error("frame 0 touched by force-low A");
   // Register A holds unless written
   a_sirqa_hold: assert property (@(posedge clock) disable iff (!resetn)
      !wrSirqA |=> sirqA_q == $past(sirqA_q))
      else $error("force-low A changed without write");
   // A forced frame of register A goes low even when no other source asks
   a_frame_low_a: assert property (@(posedge clock) disable iff (!resetn)
      sirqGenEnable && !sirqA_q[1] |-> !irqFrameOutN[1])
      else $error("frame 1 not forced low");
   // Register B bit 0 serves frame 8
   a_frame_low_b: assert property (@(posedge clock) disable iff (!resetn)
      sirqGenEnable && !sirqB_q[0] |-> !irqFrameOutN[8])
      else $error("frame 8 not forced low");
   // A disabled bank leaves frame 8 to the other sources
   a_frame_gate_b: assert property (@(posedge clock) disable iff (!resetn)
      !sirqGenEnable && !sirqB_q[0] |-> irqFrameOutN[8] == irqFrameOtherN[8])
      else $error("frame 8 forced while disabled");
   // Other sources always pass; forcing can only pull frames low
   a_frame_other: assert property (@(posedge clock) disable iff (!resetn)
      (irqFrameOutN & ~irqFrameOtherN) == 16'h0000)
      else $error("other frame source lost");
   // Released bits leave their frames to the other sources
   a_frame_release: assert property (@(posedge clock) disable iff (!resetn)
      sirqA_q == 8'hFF && sirqB_q == 8'hFF |-> irqFrameOutN == irqFrameOtherN)
      else $error("frame forced while released");

   c_force_set: cover property (@(posedge clock) wrForce && wrByte[0]);
   c_step_clear: cover property (@(posedge clock) stepDone && forceReg_q[0]);
   c_frame_low: cover property (@(posedge clock) sirqGenEnable && !sirqA_q[1]);
   c_sirq_release: cover property (@(posedge clock) !sirqB_q[0] ##1 wrSirqB ##1 sirqB_q[0]);
   c_read_behind_write: cover property (@(posedge clock) wrPend_q && addrValid && !hwrite);

endmodule

// [rmrb_units_model.sv]
// Model of the floppy and UART units that own the shadowed control registers
`timescale 1ns/10ps
module rmrb_units_model (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Load strobes (rate, UART A, UART B) and data
   input wire logic [2:0] loadSel,
   input wire logic [7:0] loadData,
   // Originating control registers
   output rmrb_pkg::rmrb_rate_t rate_q,
   output rmrb_pkg::rmrb_fifo_t fifoA_q,
   output rmrb_pkg::rmrb_fifo_t fifoB_q
);
   // Each unit takes a host write; reserved bits are kept so masking is seen
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rate_q <= '0;
         fifoA_q <= '0;
         fifoB_q <= '0;
      end else begin
         if (loadSel[0]) rate_q <= rmrb_pkg::rmrb_rate_t'(loadData);
         if (loadSel[1]) fifoA_q <= rmrb_pkg::rmrb_fifo_t'(loadData);
         if (loadSel[2]) fifoB_q <= rmrb_pkg::rmrb_fifo_t'(loadData);
      end
   end
endmodule

// [rmrb_runtime_misc_register_bank_bench.sv]
// Self-checking bench of the runtime misc register bank
`timescale 1ns/10ps
module rmrb_runtime_misc_register_bank_bench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [2:0] loadSel = 3'h0;
   logic [7:0] loadData = 8'h00;
   rmrb_pkg::rmrb_fdd_t fddPins = 3'h7;
   logic sirqGenEnable = 1'b0;
   logic [15:0] irqOtherN = 16'hFFFF;
   wire logic [31:0] hrdata;
   wire logic hready;
   wire logic flag;
   wire logic [15:0] irqOutN;
   wire rmrb_pkg::rmrb_rate_t rate;
   wire rmrb_pkg::rmrb_fifo_t fifoA;
   wire rmrb_pkg::rmrb_fifo_t fifoB;
   int bad_count = 0;
   int total_checks = 0;

   always #50 clock = ~clock;

   rmrb_units_model u_units (.clock(clock), .resetn(resetn), .loadSel(loadSel),
      .loadData(loadData), .rate_q(rate), .fifoA_q(fifoA), .fifoB_q(fifoB));

   // Single slave: its ready is the bus ready
   rmrb_runtime_misc_register_bank u_dut (.clock(clock), .resetn(resetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(), .fddPins(fddPins), .diskChangedFlag(flag), .floppyRateIn(rate),
      .uartAFifoIn(fifoA), .uartBFifoIn(fifoB), .sirqGenEnable(sirqGenEnable),
      .irqFrameOtherN(irqOtherN), .irqFrameOutN(irqOutN));

   // ------------------------------
   // Bus and compare helpers
   // ------------------------------
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait so a stuck ready ends the run
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (hready !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
   endtask

   task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= rmrb_pkg::HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata;
   endtask

   task rdchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
   endtask

   // Extra edge lets the shadow pick the new value before the read
   task load(input logic [2:0] s, input logic [7:0] d);
      loadSel <= s;
      loadData <= d;
      @(posedge clock);
      loadSel <= 3'h0;
      @(posedge clock);
   endtask

   task t_reset;
      rdchk(rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'h01);
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_A, 8'hFF);
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'hFF);
      rdchk(rmrb_pkg::IDX_RESERVED_TAIL0, 8'h00);
      rdchk(rmrb_pkg::IDX_RESERVED_TAIL1, 8'h00);
      rdchk(8'h30, 8'h00);
   endtask

   task t_force;
      fddPins <= 3'b110;
      bus(1'b1, rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'h00);
      @(negedge clock);
      chk(flag, 1'b1);
      @(posedge clock);
      rdchk(rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'h01);
      fddPins <= 3'b100;
      @(posedge clock);
      fddPins <= 3'b110;
      @(posedge clock);
      rdchk(rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'h00);
      @(negedge clock);
      chk(flag, 1'b0);
      @(posedge clock);
      fddPins <= 3'b010;
      @(negedge clock);
      chk(flag, 1'b1);
      @(posedge clock);
      fddPins <= 3'b111;
      bus(1'b1, rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'hFF);
      rdchk(rmrb_pkg::IDX_FORCE_DISK_CHANGE, 8'h01);
      @(negedge clock);
      chk(flag, 1'b0);
      @(posedge clock);
   endtask

   task t_shadow;
      load(3'h1, 8'hFF);
      load(3'h2, 8'hFF);
      load(3'h4, 8'h5A);
      bus(1'b1, rmrb_pkg::IDX_FLOPPY_RATE_SHADOW, 8'h00);
      rdchk(rmrb_pkg::IDX_FLOPPY_RATE_SHADOW, 8'hDF);
      rdchk(rmrb_pkg::IDX_UART_A_FIFO_SHADOW, 8'hCF);
      rdchk(rmrb_pkg::IDX_UART_B_FIFO_SHADOW, 8'h4A);
      load(3'h1, 8'h23);
      rdchk(rmrb_pkg::IDX_FLOPPY_RATE_SHADOW, 8'h03);
   endtask

   task t_irq;
      bus(1'b1, rmrb_pkg::IDX_SIRQ_FORCE_LOW_A, 8'h00);
      bus(1'b1, rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'h7E);
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_A, 8'h01);
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'h7E);
      chk(irqOutN, 16'hFFFF);
      sirqGenEnable <= 1'b1;
      @(negedge clock);
      chk(irqOutN, 16'h7E01);
      @(posedge clock);
      bus(1'b1, rmrb_pkg::IDX_SIRQ_FORCE_LOW_A, 8'hFF);
      bus(1'b1, rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'hFF);
      irqOtherN <= 16'h5AA5;
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'hFF);
      chk(irqOutN, 16'h5AA5);
   endtask

   // Reset in mid-run, with a bit forced and shadows loaded, restores the defaults
   task t_midreset;
      bus(1'b1, rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'h00);
      rdchk(rmrb_pkg::IDX_SIRQ_FORCE_LOW_B, 8'h00);
      resetn <= 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      chk(irqOutN, 16'h5AA5);
      t_reset();
      rdchk(rmrb_pkg::IDX_FLOPPY_RATE_SHADOW, 8'h00);
   endtask

   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_reset();
      t_force();
      t_shadow();
      t_irq();
      t_midreset();
      end_of_test();
   end
endmodule
